// *** rtl/fsp_pkg.sv ***
// Constants shared by the frame statistics pulse logic.
// Assumes a 32-bit classic Wishbone slave and 16-bit frame byte counts.
package fsp_pkg;

   // Frame length width and size bin edges in bytes
   localparam int LEN_W = 16;
   localparam logic [15:0] BIN_64 = 16'h0040;
   localparam logic [15:0] BIN_127 = 16'h007F;
   localparam logic [15:0] BIN_255 = 16'h00FF;
   localparam logic [15:0] BIN_511 = 16'h01FF;
   localparam logic [15:0] BIN_1023 = 16'h03FF;
   localparam logic [15:0] BIN_1518 = 16'h05EE;

   // Register byte offsets
   localparam logic [7:0] ADDR_TX_MAX = 8'h00;
   localparam logic [7:0] ADDR_RX_MAX = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_CTRL = 8'h0C;

   // Reset values
   localparam logic [15:0] MAX_RESET = 16'h05EE;
   localparam logic [1:0] CTRL_RESET = 2'h3;
   localparam int CTRL_TX_EN = 0;
   localparam int CTRL_RX_EN = 1;

   // Classification flag positions; transmit uses the low TX_FLAG_W
   localparam int FLAG_W = 27;
   localparam int TX_FLAG_W = 22;
   localparam int F_64 = 0;
   localparam int F_127 = 1;
   localparam int F_255 = 2;
   localparam int F_511 = 3;
   localparam int F_1023 = 4;
   localparam int F_1518 = 5;
   localparam int F_MAX = 6;
   localparam int F_OVER = 7;
   localparam int F_MC_DERR = 8;
   localparam int F_MC_DOK = 9;
   localparam int F_BC_DERR = 10;
   localparam int F_BC_DOK = 11;
   localparam int F_UC_DERR = 12;
   localparam int F_UC_DOK = 13;
   localparam int F_MC_CTRL = 14;
   localparam int F_BC_CTRL = 15;
   localparam int F_UC_CTRL = 16;
   localparam int F_PAUSE = 17;
   localparam int F_FCS = 18;
   localparam int F_FRAG = 19;
   localparam int F_JAB = 20;
   localparam int F_LGCB = 21;
   localparam int F_RUNT = 22;
   localparam int F_PAUSE_ERR = 23;
   localparam int F_MC_CERR = 24;
   localparam int F_BC_CERR = 25;
   localparam int F_UC_CERR = 26;

endpackage : fsp_pkg

// *** rtl/fsp_frame_statistics_pulses.sv ***
// Frame statistics increment pulses for the transmit and receive MAC paths.
// Assumes per-frame descriptors arrive from MAC logic on i_core_clk.
// How it works
// R1 - Each received frame of 64..1518 bytes pulses exactly one size bin.
// R2 - Receive runt pulse for a frame under 64 bytes with good checksum.
// R3 - Receive max pulse when length equals programmed receive maximum.
// R4 - Receive oversize pulse when length exceeds programmed receive maximum.
// R5 - Received non-control frames pulse one of six type/error indicators.
// R6 - Valid received control frames pulse multicast, broadcast or unicast.
// R7 - Valid received pause frames pulse the receive pause indicator.
// R8 - Received frame with checksum error pulses receive checksum indicator.
// R9 - Received frame under 64 bytes with checksum error pulses fragment.
// R10 - Oversized received frame with checksum error pulses jabber.
// R11 - Valid-size received frame with checksum error pulses its indicator.
// R12 - Errored received pause frame pulses errored pause indicator.
// R13 - Errored received control frame pulses one of three by type.
// R14 - Transmitted non-control frames pulse one of six type/error pulses.
// R15 - Valid transmitted control frames pulse multicast, broadcast, unicast.
// R16 - Valid transmitted pause frame pulses transmit pause indicator.
// R17 - Transmitted frame with checksum error pulses transmit indicator.
// R18 - Transmitted frame under 64 bytes with checksum error: fragment.
// R19 - Oversized transmitted frame with checksum error pulses jabber.
// R20 - Valid-size transmitted frame with checksum error pulses indicator.
// R21 - Software programs transmit maximum; it sets max and oversize limit.
// R22 - Each transmitted frame pulses its size bin if 64..1518 bytes, and max or oversize as they apply.
// R23 - Transmit and receive pulses come from their own path logic.
// R24 - Pulses always leave as ports and also feed the status counts.
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module fsp_frame_statistics_pulses
   import fsp_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Transmit frame descriptor
   input wire logic i_tx_frame_done,
   input wire logic [LEN_W-1:0] i_tx_frame_len,
   input wire logic i_tx_dst_mcast,
   input wire logic i_tx_dst_bcast,
   input wire logic i_tx_is_ctrl,
   input wire logic i_tx_is_pause,
   input wire logic i_tx_fcs_err,
   // Receive frame descriptor
   input wire logic i_rx_frame_done,
   input wire logic [LEN_W-1:0] i_rx_frame_len,
   input wire logic i_rx_dst_mcast,
   input wire logic i_rx_dst_bcast,
   input wire logic i_rx_is_ctrl,
   input wire logic i_rx_is_pause,
   input wire logic i_rx_fcs_err,
   // Transmit increment pulses
   output logic o_tx_inc_64,
   output logic o_tx_inc_127,
   output logic o_tx_inc_255,
   output logic o_tx_inc_511,
   output logic o_tx_inc_1023,
   output logic o_tx_inc_1518,
   output logic o_tx_inc_max,
   output logic o_tx_inc_over,
   output logic o_tx_inc_mcast_data_err,
   output logic o_tx_inc_mcast_data_ok,
   output logic o_tx_inc_bcast_data_err,
   output logic o_tx_inc_bcast_data_ok,
   output logic o_tx_inc_ucast_data_err,
   output logic o_tx_inc_ucast_data_ok,
   output logic o_tx_inc_mcast_ctrl,
   output logic o_tx_inc_bcast_ctrl,
   output logic o_tx_inc_ucast_ctrl,
   output logic o_tx_inc_pause,
   output logic o_tx_inc_fcs_err,
   output logic o_tx_inc_fragment,
   output logic o_tx_inc_jabber,
   output logic o_tx_length_good_checksum_bad_pulse,
   // Receive increment pulses
   output logic o_rx_inc_runt,
   output logic o_rx_inc_64,
   output logic o_rx_inc_127,
   output logic o_rx_inc_255,
   output logic o_rx_inc_511,
   output logic o_rx_inc_1023,
   output logic o_rx_inc_1518,
   output logic o_rx_inc_max,
   output logic o_rx_inc_over,
   output logic o_rx_inc_mcast_data_err,
   output logic o_rx_inc_mcast_data_ok,
   output logic o_rx_inc_bcast_data_err,
   output logic o_rx_inc_bcast_data_ok,
   output logic o_rx_inc_ucast_data_err,
   output logic o_rx_inc_ucast_data_ok,
   output logic o_rx_inc_mcast_ctrl,
   output logic o_rx_inc_bcast_ctrl,
   output logic o_rx_inc_ucast_ctrl,
   output logic o_rx_inc_pause,
   output logic o_rx_inc_fcs_err,
   output logic o_rx_inc_fragment,
   output logic o_rx_inc_jabber,
   output logic o_rx_length_good_checksum_bad_pulse,
   output logic o_rx_inc_pause_ctrl_err,
   output logic o_rx_inc_mcast_ctrl_err,
   output logic o_rx_inc_bcast_ctrl_err,
   output logic o_rx_inc_ucast_ctrl_err
);

   // Classify one finished frame into its full set of flags
   function automatic logic [FLAG_W-1:0] classify(
      input logic [LEN_W-1:0] len,
      input logic [LEN_W-1:0] max_len,
      input logic mc,
      input logic bc,
      input logic ctrl,
      input logic pause,
      input logic fcs
   );
      logic [FLAG_W-1:0] f;
      logic short_f;
      logic over_f;
      logic err_f;
      logic is_bc;
      logic is_mc;
      logic is_uc;
      f = '0;
      short_f = (len < BIN_64);
      over_f = (len > max_len);
      err_f = fcs | over_f | short_f;
      // Broadcast addresses are also group addresses; broadcast wins
      is_bc = bc;
      is_mc = mc & ~bc;
      is_uc = ~mc & ~bc;

      // Size bins; frames outside 64..1518 pulse none
      f[F_64] = (len == BIN_64);
      f[F_127] = (len > BIN_64) && (len <= BIN_127);
      f[F_255] = (len > BIN_127) && (len <= BIN_255);
      f[F_511] = (len > BIN_255) && (len <= BIN_511);
      f[F_1023] = (len > BIN_511) && (len <= BIN_1023);
      f[F_1518] = (len > BIN_1023) && (len <= BIN_1518);

      // Limits against the programmed maximum
      f[F_MAX] = (len == max_len);
      f[F_OVER] = over_f;

      // Data frames by destination and error
      f[F_MC_DERR] = ~ctrl & is_mc & err_f;
      f[F_MC_DOK] = ~ctrl & is_mc & ~err_f;
      f[F_BC_DERR] = ~ctrl & is_bc & err_f;
      f[F_BC_DOK] = ~ctrl & is_bc & ~err_f;
      f[F_UC_DERR] = ~ctrl & is_uc & err_f;
      f[F_UC_DOK] = ~ctrl & is_uc & ~err_f;

      // Good control and pause frames
      f[F_MC_CTRL] = ctrl & is_mc & ~err_f;
      f[F_BC_CTRL] = ctrl & is_bc & ~err_f;
      f[F_UC_CTRL] = ctrl & is_uc & ~err_f;
      f[F_PAUSE] = ctrl & pause & ~err_f;

      // Checksum error classes by length
      f[F_FCS] = fcs;
      f[F_FRAG] = short_f & fcs;
      f[F_JAB] = over_f & fcs;
      f[F_LGCB] = fcs & ~short_f & ~over_f;

      // Receive only: runt and errored control
      f[F_RUNT] = short_f & ~fcs;
      f[F_PAUSE_ERR] = ctrl & pause & err_f;
      f[F_MC_CERR] = ctrl & is_mc & err_f;
      f[F_BC_CERR] = ctrl & is_bc & err_f;
      f[F_UC_CERR] = ctrl & is_uc & err_f;
      return f;
   endfunction : classify

   // Software settings: size limits and path enables
   logic [LEN_W-1:0] tx_max_reg;
   logic [LEN_W-1:0] rx_max_reg;
   logic [1:0] ctrl_reg;

   // Frames pulsed per path, read back as status
   logic [15:0] tx_count_reg;
   logic [15:0] rx_count_reg;

   // Pulse registers, one cycle per finished frame
   logic [TX_FLAG_W-1:0] tx_flags_reg;
   logic [FLAG_W-1:0] rx_flags_reg;

   // Live classification of the current descriptors
   logic [FLAG_W-1:0] tx_class;
   logic [FLAG_W-1:0] rx_class;

   // Bus request decode and read data
   logic wb_req;
   logic wb_wr;
   logic [31:0] rd_next;

   // Frame classification from the live descriptors
   assign tx_class = classify(i_tx_frame_len, tx_max_reg, i_tx_dst_mcast,
      i_tx_dst_bcast, i_tx_is_ctrl, i_tx_is_pause, i_tx_fcs_err); // R21
   assign rx_class = classify(i_rx_frame_len, rx_max_reg, i_rx_dst_mcast,
      i_rx_dst_bcast, i_rx_is_ctrl, i_rx_is_pause, i_rx_fcs_err);

   // Bus request decode; one wait state, ack dropped after one cycle
   assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign wb_wr = wb_req & i_wb_we;

   // Transmit pulse register, one cycle per finished frame
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         tx_flags_reg <= '0;
      end else if (i_tx_frame_done && ctrl_reg[CTRL_TX_EN]) begin
         tx_flags_reg <= tx_class[TX_FLAG_W-1:0]; // R14 R15 R16 R22 R23
      end else begin
         tx_flags_reg <= '0;
      end
   end

   // Receive pulse register, one cycle per finished frame
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rx_flags_reg <= '0;
      end else if (i_rx_frame_done && ctrl_reg[CTRL_RX_EN]) begin
         rx_flags_reg <= rx_class; // R1 R2 R3 R4 R5 R6 R7 R23
      end else begin
         rx_flags_reg <= '0;
      end
   end

   // Transmit frame count seen by software, fed from the same pulses
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         tx_count_reg <= '0;
      end else if (|tx_flags_reg) begin
         tx_count_reg <= tx_count_reg + 16'h0001; // R24
      end
   end

   // Receive frame count; wraps, so software reads the difference
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rx_count_reg <= '0;
      end else if (|rx_flags_reg) begin
         rx_count_reg <= rx_count_reg + 16'h0001; // R24
      end
   end

   // Configuration writes with byte lane strobes
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         tx_max_reg <= MAX_RESET;
         rx_max_reg <= MAX_RESET;
         ctrl_reg <= CTRL_RESET;
      end else if (wb_wr) begin
         case (i_wb_adr)
            ADDR_TX_MAX: begin
               if (i_wb_sel[0]) tx_max_reg[7:0] <= i_wb_dat[7:0]; // R21
               if (i_wb_sel[1]) tx_max_reg[15:8] <= i_wb_dat[15:8];
            end
            ADDR_RX_MAX: begin
               if (i_wb_sel[0]) rx_max_reg[7:0] <= i_wb_dat[7:0];
               if (i_wb_sel[1]) rx_max_reg[15:8] <= i_wb_dat[15:8];
            end
            ADDR_CTRL: begin
               if (i_wb_sel[0]) ctrl_reg <= i_wb_dat[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Read data mux; unmapped offsets read zero
   always_comb begin
      rd_next = '0;
      case (i_wb_adr)
         ADDR_TX_MAX: rd_next = {16'h0000, tx_max_reg};
         ADDR_RX_MAX: rd_next = {16'h0000, rx_max_reg};
         ADDR_STATUS: rd_next = {rx_count_reg, tx_count_reg};
         ADDR_CTRL: rd_next = {30'h00000000, ctrl_reg};
         default: rd_next = '0;
      endcase
   end

   // Bus answer registers
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= '0;
      end else begin
         o_wb_ack <= wb_req;
         o_wb_dat <= wb_req ? rd_next : 32'h00000000;
      end
   end

   // Transmit pulse outputs
   assign o_tx_inc_64 = tx_flags_reg[F_64];
   assign o_tx_inc_127 = tx_flags_reg[F_127];
   assign o_tx_inc_255 = tx_flags_reg[F_255];
   assign o_tx_inc_511 = tx_flags_reg[F_511];
   assign o_tx_inc_1023 = tx_flags_reg[F_1023];
   assign o_tx_inc_1518 = tx_flags_reg[F_1518];

   // Transmit size limit pulses
   assign o_tx_inc_max = tx_flags_reg[F_MAX];
   assign o_tx_inc_over = tx_flags_reg[F_OVER];

   // Transmit data frame pulses
   assign o_tx_inc_mcast_data_err = tx_flags_reg[F_MC_DERR];
   assign o_tx_inc_mcast_data_ok = tx_flags_reg[F_MC_DOK];
   assign o_tx_inc_bcast_data_err = tx_flags_reg[F_BC_DERR];
   assign o_tx_inc_bcast_data_ok = tx_flags_reg[F_BC_DOK];
   assign o_tx_inc_ucast_data_err = tx_flags_reg[F_UC_DERR];
   assign o_tx_inc_ucast_data_ok = tx_flags_reg[F_UC_DOK];

   // Transmit good control and pause pulses
   assign o_tx_inc_mcast_ctrl = tx_flags_reg[F_MC_CTRL];
   assign o_tx_inc_bcast_ctrl = tx_flags_reg[F_BC_CTRL];
   assign o_tx_inc_ucast_ctrl = tx_flags_reg[F_UC_CTRL];
   assign o_tx_inc_pause = tx_flags_reg[F_PAUSE];

   // Transmit checksum error pulses
   assign o_tx_inc_fcs_err = tx_flags_reg[F_FCS]; // R17
   assign o_tx_inc_fragment = tx_flags_reg[F_FRAG]; // R18
   assign o_tx_inc_jabber = tx_flags_reg[F_JAB]; // R19
   assign o_tx_length_good_checksum_bad_pulse = tx_flags_reg[F_LGCB]; // R20

   // Receive pulse outputs
   assign o_rx_inc_runt = rx_flags_reg[F_RUNT];

   // Receive size bin pulses
   assign o_rx_inc_64 = rx_flags_reg[F_64];
   assign o_rx_inc_127 = rx_flags_reg[F_127];
   assign o_rx_inc_255 = rx_flags_reg[F_255];
   assign o_rx_inc_511 = rx_flags_reg[F_511];
   assign o_rx_inc_1023 = rx_flags_reg[F_1023];
   assign o_rx_inc_1518 = rx_flags_reg[F_1518];

   // Receive size limit pulses
   assign o_rx_inc_max = rx_flags_reg[F_MAX];
   assign o_rx_inc_over = rx_flags_reg[F_OVER];

   // Receive data frame pulses
   assign o_rx_inc_mcast_data_err = rx_flags_reg[F_MC_DERR];
   assign o_rx_inc_mcast_data_ok = rx_flags_reg[F_MC_DOK];
   assign o_rx_inc_bcast_data_err = rx_flags_reg[F_BC_DERR];
   assign o_rx_inc_bcast_data_ok = rx_flags_reg[F_BC_DOK];
   assign o_rx_inc_ucast_data_err = rx_flags_reg[F_UC_DERR];
   assign o_rx_inc_ucast_data_ok = rx_flags_reg[F_UC_DOK];

   // Receive good control and pause pulses
   assign o_rx_inc_mcast_ctrl = rx_flags_reg[F_MC_CTRL];
   assign o_rx_inc_bcast_ctrl = rx_flags_reg[F_BC_CTRL];
   assign o_rx_inc_ucast_ctrl = rx_flags_reg[F_UC_CTRL];
   assign o_rx_inc_pause = rx_flags_reg[F_PAUSE];

   // Receive checksum error pulses
   assign o_rx_inc_fcs_err = rx_flags_reg[F_FCS]; // R8
   assign o_rx_inc_fragment = rx_flags_reg[F_FRAG]; // R9
   assign o_rx_inc_jabber = rx_flags_reg[F_JAB]; // R10
   assign o_rx_length_good_checksum_bad_pulse = rx_flags_reg[F_LGCB]; // R11

   // Receive errored control pulses
   assign o_rx_inc_pause_ctrl_err = rx_flags_reg[F_PAUSE_ERR]; // R12
   assign o_rx_inc_mcast_ctrl_err = rx_flags_reg[F_MC_CERR]; // R13
   assign o_rx_inc_bcast_ctrl_err = rx_flags_reg[F_BC_CERR]; // R13
   assign o_rx_inc_ucast_ctrl_err = rx_flags_reg[F_UC_CERR]; // R13

endmodule : fsp_frame_statistics_pulses
`default_nettype wire

// *** verification/fsp_frame_statistics_pulses_asserts.sv ***
// Checker of the frame statistics pulses, bound to the top module.
// Assumes one core clock and the design package compiled first.
`timescale 1ns/1ps
`default_nettype none
module fsp_stats_checker
   import fsp_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_tx_frame_done,
   input wire logic i_tx_is_ctrl,
   input wire logic i_tx_is_pause,
   input wire logic i_tx_fcs_err,
   input wire logic i_rx_frame_done,
   input wire logic [LEN_W-1:0] i_rx_frame_len,
   input wire logic i_rx_dst_mcast,
   input wire logic i_rx_dst_bcast,
   input wire logic i_rx_is_ctrl,
   input wire logic i_rx_fcs_err,
   input wire logic o_tx_inc_pause,
   input wire logic o_tx_inc_fcs_err,
   input wire logic o_rx_inc_runt,
   input wire logic o_rx_inc_64,
   input wire logic o_rx_inc_127,
   input wire logic o_rx_inc_ucast_ctrl,
   input wire logic o_rx_inc_fragment
);
   // All checks sample on the core clock and rest during reset
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   // Receive pulses follow the descriptor taken one cycle before
   rx_bin_64_a: assert property (o_rx_inc_64 |->
      $past(i_rx_frame_done) && $past(i_rx_frame_len) == BIN_64)
      else $error("64 byte bin without a 64 byte frame");
   rx_bin_127_a: assert property (o_rx_inc_127 |->
      $past(i_rx_frame_len) > BIN_64 && $past(i_rx_frame_len) <= BIN_127)
      else $error("127 byte bin with a length outside it");
   rx_runt_a: assert property (o_rx_inc_runt |->
      $past(i_rx_frame_len) < BIN_64 && !$past(i_rx_fcs_err))
      else $error("runt pulse without a short good frame");
   rx_fragment_a: assert property (o_rx_inc_fragment |->
      $past(i_rx_frame_len) < BIN_64 && $past(i_rx_fcs_err))
      else $error("fragment pulse without a short bad frame");
   rx_ucast_ctrl_a: assert property (o_rx_inc_ucast_ctrl |->
      $past(i_rx_is_ctrl) && !$past(i_rx_fcs_err)
      && !$past(i_rx_dst_mcast) && !$past(i_rx_dst_bcast))
      else $error("unicast control pulse without its frame");

   // Transmit pulses
   tx_fcs_cause_a: assert property (o_tx_inc_fcs_err |->
      $past(i_tx_frame_done) && $past(i_tx_fcs_err))
      else $error("transmit checksum pulse without a bad frame");
   tx_fcs_single_a: assert property (
      o_tx_inc_fcs_err && !i_tx_frame_done |=> !o_tx_inc_fcs_err)
      else $error("transmit checksum pulse longer than one cycle");
   tx_pause_ok_a: assert property (o_tx_inc_pause |->
      $past(i_tx_is_ctrl) && $past(i_tx_is_pause) && !$past(i_tx_fcs_err))
      else $error("transmit pause pulse without a good pause frame");
endmodule : fsp_stats_checker
bind fsp_frame_statistics_pulses fsp_stats_checker i_chk (.*);
`default_nettype wire

// *** verification/fsp_stat_model.sv ***
// Model of the counters and user logic fed by the increment pulses.
// Assumes pulses packed in flag order, all on the core clock.
`timescale 1ns/1ps
`default_nettype none
module fsp_stat_model
   import fsp_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [TX_FLAG_W-1:0] i_tx_pulses,
   input wire logic [FLAG_W-1:0] i_rx_pulses,
   output logic [15:0] o_tx_frames,
   output logic [15:0] o_rx_frames
);
   // One count per cycle in which a path shows any pulse
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_tx_frames <= 16'h0000;
         o_rx_frames <= 16'h0000;
      end else begin
         o_tx_frames <= o_tx_frames + 16'(|i_tx_pulses);
         o_rx_frames <= o_rx_frames + 16'(|i_rx_pulses);
      end
   end
endmodule : fsp_stat_model
`default_nettype wire

// *** verification/fsp_frame_statistics_pulses_tb_top.sv ***
// Self-checking bench of the frame statistics pulse block.
// Assumes package, design, checker and counter model compile first.
`timescale 1ns/1ps
`default_nettype none
module fsp_frame_statistics_pulses_tb_top
   import fsp_pkg::*;
;
   logic i_core_clk = 1'b0, i_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, te, re, seed = 32'h3078;
   logic ack;
   // Per path fields, index 0 transmit and 1 receive
   logic [1:0] done = 2'h0, mc = 2'h0, bc = 2'h0;
   logic [1:0] ct = 2'h0, pa = 2'h0, fe = 2'h0, en = 2'h3;
   logic [1:0][15:0] len = '0, mx = {MAX_RESET, MAX_RESET};
   logic [15:0] lt [14] = '{16'h003F, 16'h0040, 16'h0041, 16'h007F,
      16'h0080, 16'h00FF, 16'h0100, 16'h01FF, 16'h0200, 16'h03FF,
      16'h0400, 16'h05CD, 16'h05EE, 16'h05EF};
   logic [TX_FLAG_W-1:0] t;
   logic [FLAG_W-1:0] r, txq[$], rxq[$];
   logic [15:0] mtx, mrx;
   int nf[2] = '{0, 0};
   int fail_count = 0;
   int comparisons = 0;

   // Core clock, 10 ns period
   initial forever #5 i_core_clk = ~i_core_clk;

   fsp_frame_statistics_pulses i_dut (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_tx_frame_done(done[0]),
      .i_tx_frame_len(len[0]), .i_tx_dst_mcast(mc[0]), .i_tx_dst_bcast(bc[0]),
      .i_tx_is_ctrl(ct[0]), .i_tx_is_pause(pa[0]), .i_tx_fcs_err(fe[0]),
      .i_rx_frame_done(done[1]), .i_rx_frame_len(len[1]),
      .i_rx_dst_mcast(mc[1]), .i_rx_dst_bcast(bc[1]), .i_rx_is_ctrl(ct[1]),
      .i_rx_is_pause(pa[1]), .i_rx_fcs_err(fe[1]),
      .o_tx_inc_64(t[0]), .o_tx_inc_127(t[1]), .o_tx_inc_255(t[2]),
      .o_tx_inc_511(t[3]), .o_tx_inc_1023(t[4]), .o_tx_inc_1518(t[5]),
      .o_tx_inc_max(t[6]), .o_tx_inc_over(t[7]),
      .o_tx_inc_mcast_data_err(t[8]), .o_tx_inc_mcast_data_ok(t[9]),
      .o_tx_inc_bcast_data_err(t[10]), .o_tx_inc_bcast_data_ok(t[11]),
      .o_tx_inc_ucast_data_err(t[12]), .o_tx_inc_ucast_data_ok(t[13]),
      .o_tx_inc_mcast_ctrl(t[14]), .o_tx_inc_bcast_ctrl(t[15]),
      .o_tx_inc_ucast_ctrl(t[16]), .o_tx_inc_pause(t[17]),
      .o_tx_inc_fcs_err(t[18]), .o_tx_inc_fragment(t[19]),
      .o_tx_inc_jabber(t[20]), .o_tx_length_good_checksum_bad_pulse(t[21]),
      .o_rx_inc_64(r[0]), .o_rx_inc_127(r[1]), .o_rx_inc_255(r[2]),
      .o_rx_inc_511(r[3]), .o_rx_inc_1023(r[4]), .o_rx_inc_1518(r[5]),
      .o_rx_inc_max(r[6]), .o_rx_inc_over(r[7]),
      .o_rx_inc_mcast_data_err(r[8]), .o_rx_inc_mcast_data_ok(r[9]),
      .o_rx_inc_bcast_data_err(r[10]), .o_rx_inc_bcast_data_ok(r[11]),
      .o_rx_inc_ucast_data_err(r[12]), .o_rx_inc_ucast_data_ok(r[13]),
      .o_rx_inc_mcast_ctrl(r[14]), .o_rx_inc_bcast_ctrl(r[15]),
      .o_rx_inc_ucast_ctrl(r[16]), .o_rx_inc_pause(r[17]),
      .o_rx_inc_fcs_err(r[18]), .o_rx_inc_fragment(r[19]),
      .o_rx_inc_jabber(r[20]), .o_rx_length_good_checksum_bad_pulse(r[21]),
      .o_rx_inc_runt(r[22]), .o_rx_inc_pause_ctrl_err(r[23]),
      .o_rx_inc_mcast_ctrl_err(r[24]), .o_rx_inc_bcast_ctrl_err(r[25]),
      .o_rx_inc_ucast_ctrl_err(r[26]));

   fsp_stat_model i_model (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .i_tx_pulses(t), .i_rx_pulses(r), .o_tx_frames(mtx), .o_rx_frames(mrx));

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Classic Wishbone cycle; data is taken at the edge that samples ack
   task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
      int n = 0;
      @(posedge i_core_clk);
      {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, s};
      do begin
         @(posedge i_core_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         report_and_stop();
      end
      q = rdat;
      {cyc, stb} <= 2'h0;
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, 4'hF, q);
      chk(q, e);
   endtask : rd

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   // Expected pulse set of one frame; a is {mcast, bcast, ctrl, pause, fcs}
   function automatic logic [FLAG_W-1:0] expv(input logic p,
      input logic [15:0] l, input logic [15:0] m, input logic [4:0] a);
      logic sh, ov, er;
      int k;
      logic [FLAG_W-1:0] v = '0;
      sh = l < BIN_64;
      ov = l > m;
      er = a[0] | sh | ov;
      k = a[3] ? 1 : (a[4] ? 0 : 2);
      v[F_64] = l == BIN_64;
      v[F_127] = l > BIN_64 && l <= BIN_127;
      v[F_255] = l > BIN_127 && l <= BIN_255;
      v[F_511] = l > BIN_255 && l <= BIN_511;
      v[F_1023] = l > BIN_511 && l <= BIN_1023;
      v[F_1518] = l > BIN_1023 && l <= BIN_1518;
      {v[F_MAX], v[F_OVER], v[F_FCS]} = {l == m, ov, a[0]};
      v[F_MC_DERR + 2 * k + int'(!er)] = !a[2];
      v[F_MC_CTRL + k] = a[2] & !er;
      v[F_PAUSE] = a[2] & a[1] & !er;
      {v[F_FRAG], v[F_JAB]} = {sh & a[0], ov & a[0]};
      v[F_LGCB] = a[0] & !sh & !ov;
      if (p) begin
         {v[F_RUNT], v[F_PAUSE_ERR]} = {sh & !a[0], a[2] & a[1] & er};
         v[F_MC_CERR + k] = a[2] & er;
      end
      return v;
   endfunction : expv

   // Drive one descriptor and note its pulses when the path is enabled
   task automatic frame(input logic p, input logic [15:0] l,
      input logic [4:0] a);
      logic [FLAG_W-1:0] v;
      @(posedge i_core_clk);
      done <= p ? 2'h2 : 2'h1;
      len[p] <= l;
      {mc[p], bc[p], ct[p], pa[p], fe[p]} <= a;
      v = expv(p, l, mx[p], a);
      if (en[p] && v !== '0) begin
         nf[p]++;
         if (p) rxq.push_back(v);
         else txq.push_back(v);
      end
   endtask : frame

   task automatic idle;
      @(posedge i_core_clk);
      done <= 2'h0;
   endtask : idle

   task automatic burst(input int n);
      repeat (n) begin
         seed = xs(seed);
         if (seed[20]) idle();
         frame(seed[0], {5'h00, seed[11:1]}, seed[16:12]);
      end
      idle();
   endtask : burst

   // Watcher: each pulse set takes the oldest note of its path
   always @(negedge i_core_clk) begin
      if (!i_rst && t !== '0) begin
         te = txq.size() > 0 ? 32'(txq.pop_front()) : 32'h0;
         chk(32'(t), te);
      end
      if (!i_rst && r !== '0) begin
         re = rxq.size() > 0 ? 32'(rxq.pop_front()) : 32'h0;
         chk(32'(r[7:0]), re & 32'h000000FF);
         chk(32'(r >> 8), re >> 8);
      end
   end

   // Main sequence: registers, directed table, random, disabled path
   initial begin
      logic [31:0] q;
      repeat (12) @(posedge i_core_clk);
      i_rst <= 1'b0;
      rd(ADDR_TX_MAX, 32'h000005EE);
      rd(ADDR_RX_MAX, 32'h000005EE);
      rd(ADDR_CTRL, 32'h00000003);
      wb(1'b1, 8'h10, 32'h0000FFFF, 4'hF, q);
      rd(8'h10, 32'h0);
      wb(1'b1, ADDR_TX_MAX, 32'h0000ABCD, 4'h1, q);
      mx[0] = 16'h05CD;
      rd(ADDR_TX_MAX, 32'h000005CD);
      for (int i = 0; i < 128; i++) begin
         frame(i[5], lt[i % 14], i[4:0] ^ {4'h0, i[6]});
      end
      burst(150);
      wb(1'b1, ADDR_CTRL, 32'h00000001, 4'hF, q);
      en = 2'h1;
      burst(40);
      wb(1'b1, ADDR_CTRL, 32'h00000002, 4'hF, q);
      en = 2'h2;
      burst(40);
      wb(1'b1, ADDR_CTRL, 32'h00000003, 4'hF, q);
      en = 2'h3;
      wb(1'b1, ADDR_RX_MAX, 32'h00000100, 4'hF, q);
      mx[1] = 16'h0100;
      burst(150);
      repeat (3) @(posedge i_core_clk);
      chk(32'(txq.size() + rxq.size()), 32'h0);
      rd(ADDR_STATUS, {16'(nf[1]), 16'(nf[0])});
      chk({mrx, mtx}, {16'(nf[1]), 16'(nf[0])});
      report_and_stop();
   end
endmodule : fsp_frame_statistics_pulses_tb_top
`default_nettype wire
